// ===== design/abs_chain.v
// Boundary-scan data register with analog converter cells and port cells.
`timescale 1ns/10ps
`include "abs_consts.vh"
module abs_chain #(
   parameter LEN = `ABS_CHAIN_LEN
) (
   // Clock and reset
   input  wire           sys_clk,
   input  wire           arst_n,
   // Test access pins
   input  wire           tck,
   input  wire           tms,
   input  wire           tdi,
   input  wire           chain_selected,
   output reg            tdo_out,
   output reg            tdo_oe,
   // Observed device signals, captured into the chain
   input  wire [LEN-1:0] capture_bits,
   input  wire           analog_cmp_result,
   input  wire           analog_above_level,
   // Cell outputs applied to the device
   output reg  [LEN-1:0] update_cells,
   output reg            converter_ready,
   output reg            conv_cmp_result
);
   // ---------------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------------
   reg  [2:0] tck_sync_reg;
   reg  [2:0] tms_sync_reg;
   reg  [2:0] tdi_sync_reg;
   reg        tck_level_reg;
   reg        tms_level_reg;
   reg        tdi_level_reg;
   reg  [2:0] acmp_sync_reg;
   reg        acmp_level_reg;
   wire       tck_rise;
   wire       tck_fall;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tck_sync_reg  <= 3'h0;
         tms_sync_reg  <= 3'h7;
         tdi_sync_reg  <= 3'h0;
         tck_level_reg <= 1'b0;
         tms_level_reg <= 1'b1;
         tdi_level_reg <= 1'b0;
         acmp_sync_reg  <= 3'h0;
         acmp_level_reg <= 1'b0;
      end else begin
         // The comparator output is analog and asynchronous to this clock.
         acmp_sync_reg <= {acmp_sync_reg[1:0], analog_cmp_result};
         if (acmp_sync_reg[1] == acmp_sync_reg[2]) begin
            acmp_level_reg <= acmp_sync_reg[2];
         end
         tck_sync_reg <= {tck_sync_reg[1:0], tck};
         tms_sync_reg <= {tms_sync_reg[1:0], tms};
         tdi_sync_reg <= {tdi_sync_reg[1:0], tdi};
         if (tck_sync_reg[1] == tck_sync_reg[2]) begin
            tck_level_reg <= tck_sync_reg[2];
         end
         if (tms_sync_reg[1] == tms_sync_reg[2]) begin
            tms_level_reg <= tms_sync_reg[2];
         end
         if (tdi_sync_reg[1] == tdi_sync_reg[2]) begin
            tdi_level_reg <= tdi_sync_reg[2];
         end
      end
   end

   assign tck_rise = (tck_sync_reg[1] == tck_sync_reg[2]) && tck_sync_reg[2] && !tck_level_reg;
   assign tck_fall = (tck_sync_reg[1] == tck_sync_reg[2]) && !tck_sync_reg[2] && tck_level_reg;

   // ---------------------------------------------------------------------
   // Controller state machine
   // ---------------------------------------------------------------------
   reg [3:0] state_reg;
   reg [3:0] state_next;

   function [3:0] tap_next;
      input [3:0] st;
      input       m;
      begin
         case (st)
            `ABS_ST_RESET:    tap_next = m ? `ABS_ST_RESET    : `ABS_ST_IDLE;
            `ABS_ST_IDLE:     tap_next = m ? `ABS_ST_SEL_DR   : `ABS_ST_IDLE;
            `ABS_ST_SEL_DR:   tap_next = m ? `ABS_ST_SEL_IR   : `ABS_ST_CAP_DR;
            `ABS_ST_CAP_DR:   tap_next = m ? `ABS_ST_EXIT1_DR : `ABS_ST_SHIFT_DR;
            `ABS_ST_SHIFT_DR: tap_next = m ? `ABS_ST_EXIT1_DR : `ABS_ST_SHIFT_DR;
            `ABS_ST_EXIT1_DR: tap_next = m ? `ABS_ST_UPD_DR   : `ABS_ST_PAUSE_DR;
            `ABS_ST_PAUSE_DR: tap_next = m ? `ABS_ST_EXIT2_DR : `ABS_ST_PAUSE_DR;
            `ABS_ST_EXIT2_DR: tap_next = m ? `ABS_ST_UPD_DR   : `ABS_ST_SHIFT_DR;
            `ABS_ST_UPD_DR:   tap_next = m ? `ABS_ST_SEL_DR   : `ABS_ST_IDLE;
            `ABS_ST_SEL_IR:   tap_next = m ? `ABS_ST_RESET    : `ABS_ST_CAP_IR;
            `ABS_ST_CAP_IR:   tap_next = m ? `ABS_ST_EXIT1_IR : `ABS_ST_SHIFT_IR;
            `ABS_ST_SHIFT_IR: tap_next = m ? `ABS_ST_EXIT1_IR : `ABS_ST_SHIFT_IR;
            `ABS_ST_EXIT1_IR: tap_next = m ? `ABS_ST_UPD_IR   : `ABS_ST_PAUSE_IR;
            `ABS_ST_PAUSE_IR: tap_next = m ? `ABS_ST_EXIT2_IR : `ABS_ST_PAUSE_IR;
            `ABS_ST_EXIT2_IR: tap_next = m ? `ABS_ST_UPD_IR   : `ABS_ST_SHIFT_IR;
            `ABS_ST_UPD_IR:   tap_next = m ? `ABS_ST_SEL_DR   : `ABS_ST_IDLE;
            default:          tap_next = `ABS_ST_RESET;
         endcase
      end
   endfunction

   always @* begin
      state_next = state_reg;
      if (tck_rise) begin
         state_next = tap_next(state_reg, tms_level_reg);
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= `ABS_ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------------
   // Shift register and update latch
   // ---------------------------------------------------------------------
   // The cell map is fixed by position: converter cells from 97 to 140, port B
   // from 96, port D, port C without the four test pins, then port A reversed
   // so that its pin 0 lands on cells 2..0 next to the serial output.
   reg  [LEN-1:0] shift_reg;
   reg  [LEN-1:0] captured;
   wire           shift_pulse;
   wire           fifo_out_valid;
   wire           fifo_out_data;
   wire           fifo_in_ready;

   always @* begin
      captured = capture_bits;
      captured[`ABS_POS_CMP_RESULT]  = acmp_level_reg;
      captured[`ABS_POS_CONV_RESULT] = conv_cmp_result;
   end

   assign shift_pulse = tck_rise && chain_selected && (state_reg == `ABS_ST_SHIFT_DR);

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_reg <= {LEN{1'b0}};
      end else if (tck_rise && chain_selected && state_reg == `ABS_ST_CAP_DR) begin
         shift_reg <= captured;
      end else if (shift_pulse && fifo_in_ready) begin
         shift_reg <= {tdi_level_reg, shift_reg[LEN-1:1]};
      end
   end

   // Shifted-out bits queue here; the output pin takes one per falling edge.
   abs_fifo #(
      .WIDTH (1),
      .DEPTH (16),
      .AW    (4)
   ) u_out_fifo (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .in_valid  (shift_pulse),
      .in_ready  (fifo_in_ready),
      .in_data   (shift_reg[0]),
      .out_valid (fifo_out_valid),
      .out_ready (tck_fall),
      .out_data  (fifo_out_data)
   );

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tdo_out <= 1'b0;
         tdo_oe  <= 1'b0;
      end else if (tck_fall) begin
         tdo_out <= fifo_out_valid ? fifo_out_data : tdo_out;
         tdo_oe  <= chain_selected && (state_reg == `ABS_ST_SHIFT_DR);
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         update_cells <= {LEN{1'b0}};
      end else if (state_reg == `ABS_ST_RESET) begin
         update_cells <= {LEN{1'b0}};
      end else if (tck_fall && chain_selected && state_reg == `ABS_ST_UPD_DR) begin
         update_cells <= shift_reg;
      end
   end

   // ---------------------------------------------------------------------
   // Converter behaviour driven by the cells
   // ---------------------------------------------------------------------
   localparam [31:0] DUMMY_INIT  = `ABS_DUMMY_CMPS;
   localparam [31:0] SETTLE_INIT = `ABS_SETTLE_CYC;
   reg        conv_en_prev_reg;
   reg [3:0]  dummy_cnt_reg;
   reg [7:0]  settle_cnt_reg;
   reg        held_above_reg;
   wire       conv_en;
   wire       track_n;
   wire       cmp_latch_precharge_n_n;

   assign conv_en = update_cells[`ABS_POS_CONV_EN];
   assign track_n = update_cells[`ABS_POS_HOLD];
   assign cmp_latch_precharge_n_n = update_cells[`ABS_POS_CMP_LATCH_PRECHARGE_N_N];

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_en_prev_reg <= 1'b0;
         dummy_cnt_reg    <= 4'h0;
         settle_cnt_reg   <= 8'h00;
         converter_ready  <= 1'b0;
         held_above_reg   <= 1'b0;
         conv_cmp_result  <= 1'b0;
      end else begin
         conv_en_prev_reg <= conv_en;
         if (!conv_en) begin
            dummy_cnt_reg   <= 4'h0;
            settle_cnt_reg  <= 8'h00;
            converter_ready <= 1'b0;
         end else if (!conv_en_prev_reg) begin
            dummy_cnt_reg   <= DUMMY_INIT[3:0];
            settle_cnt_reg  <= SETTLE_INIT[7:0];
         end else begin
            if (dummy_cnt_reg != 4'h0) begin
               dummy_cnt_reg <= dummy_cnt_reg - 4'h1;
            end
            if (settle_cnt_reg != 8'h00) begin
               settle_cnt_reg <= settle_cnt_reg - 8'h01;
            end
            converter_ready <= (dummy_cnt_reg == 4'h0) && (settle_cnt_reg == 8'h00);
         end
         if (!track_n) begin
            held_above_reg <= analog_above_level;
         end
         if (!cmp_latch_precharge_n_n) begin
            conv_cmp_result <= 1'b0;
         end else if (converter_ready) begin
            conv_cmp_result <= track_n ? held_above_reg : analog_above_level;
         end
      end
   end
endmodule // abs_chain

// ===== design/abs_consts.vh
// Constants for the boundary-scan data register of the analog and port cells.
`ifndef ABS_CONSTS_VH
`define ABS_CONSTS_VH
`define ABS_CHAIN_LEN       141
`define ABS_POS_SLEEP       140
`define ABS_POS_CMP_RESULT  139
`define ABS_POS_MUX_SEL_EN  138
`define ABS_POS_INT_REF     137
`define ABS_POS_CONV_RESULT 136
`define ABS_POS_RSV_A       135
`define ABS_POS_CONV_CLK    134
`define ABS_POS_TEST_EN     133
`define ABS_POS_RSV_B       132
`define ABS_POS_REF_CONV    131
`define ABS_POS_CONV_EN     130
`define ABS_POS_GAIN_PWR    129
`define ABS_POS_LEVEL_MSB   128
`define ABS_POS_LEVEL_LSB   119
`define ABS_POS_BYPASS      118
`define ABS_POS_HOLD        114
`define ABS_POS_PASSGATE    101
`define ABS_POS_CHAN_MSB    112
`define ABS_POS_CHAN_LSB    105
`define ABS_POS_CMP_LATCH_PRECHARGE_N_N     100
`define ABS_POS_PORTB_TOP   96
`define ABS_POS_PORTA_TOP   23
`define ABS_PORT_BITS       8
`define ABS_TAP_FIRST_PC    2
`define ABS_TAP_LAST_PC     5
`define ABS_LEVEL_MID       10'h200
`define ABS_DUMMY_CMPS      10
`define ABS_SETTLE_NS       200
`define ABS_CLK_NS          20
`define ABS_SETTLE_CYC      ((`ABS_SETTLE_NS + `ABS_CLK_NS - 1) / `ABS_CLK_NS)
`define ABS_ST_RESET        4'h0
`define ABS_ST_IDLE         4'h1
`define ABS_ST_SEL_DR       4'h2
`define ABS_ST_CAP_DR       4'h3
`define ABS_ST_SHIFT_DR     4'h4
`define ABS_ST_EXIT1_DR     4'h5
`define ABS_ST_PAUSE_DR     4'h6
`define ABS_ST_EXIT2_DR     4'h7
`define ABS_ST_UPD_DR       4'h8
`define ABS_ST_SEL_IR       4'h9
`define ABS_ST_CAP_IR       4'ha
`define ABS_ST_SHIFT_IR     4'hb
`define ABS_ST_EXIT1_IR     4'hc
`define ABS_ST_PAUSE_IR     4'hd
`define ABS_ST_EXIT2_IR     4'he
`define ABS_ST_UPD_IR       4'hf
`endif

// ===== design/abs_fifo.v
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
module abs_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             arst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            do_wr;
   wire            do_rd;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_reg];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_reg <= count_reg + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // abs_fifo

// ===== tb/abs_chain_sva.sv
// Concurrent checks on the ports of the boundary-scan chain.
`timescale 1ns/10ps
`include "abs_consts.vh"
module abs_chain_sva #(
   parameter LEN = `ABS_CHAIN_LEN
) (
   // Clock and reset
   input wire           sys_clk,
   input wire           arst_n,
   // Test pins
   input wire           tck,
   input wire           tms,
   input wire           tdi,
   input wire           chain_selected,
   input wire           tdo_out,
   input wire           tdo_oe,
   // Device side
   input wire [LEN-1:0] capture_bits,
   input wire           analog_cmp_result,
   input wire           analog_above_level,
   input wire [LEN-1:0] update_cells,
   input wire           converter_ready,
   input wire           conv_cmp_result
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire en = update_cells[`ABS_POS_CONV_EN];
   wire pc = update_cells[`ABS_POS_CMP_LATCH_PRECHARGE_N_N];
   wire hd = update_cells[`ABS_POS_HOLD];
   property p_oe; tdo_oe |-> chain_selected; endproperty
   a_oe: assert property (p_oe) else $error("tdo driven while unselected");
   property p_unsel; !chain_selected && !$past(chain_selected) |-> $stable(update_cells); endproperty
   a_unsel: assert property (p_unsel) else $error("cells moved while unselected");
   property p_fall; !$stable(update_cells) && (update_cells != 0) |-> !$past(tck, 2); endproperty
   a_fall: assert property (p_fall) else $error("cells moved off a tck fall");
   property p_rdy_en; !en && !$past(en) |-> !converter_ready; endproperty
   a_rdy_en: assert property (p_rdy_en) else $error("ready without enable");
   property p_rdy_late; $rose(en) |-> !converter_ready [*8]; endproperty
   a_rdy_late: assert property (p_rdy_late) else $error("ready too early");
   property p_rdy_time; $rose(en) |-> ##[1:40] (converter_ready || !en); endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("ready too late");
   property p_cmp_latch_precharge_n; (converter_ready && !pc) [*3] |-> !conv_cmp_result; endproperty
   a_cmp_latch_precharge_n: assert property (p_cmp_latch_precharge_n) else $error("result high in precharge");
   property p_track;
      (converter_ready && pc && !hd && $stable(analog_above_level)) [*3]
         |-> conv_cmp_result == analog_above_level;
   endproperty
   a_track: assert property (p_track) else $error("result not tracking");
   property p_hold; (converter_ready && pc && hd) [*4] |-> $stable(conv_cmp_result); endproperty
   a_hold: assert property (p_hold) else $error("held result moved");
endmodule // abs_chain_sva
bind abs_chain abs_chain_sva #(.LEN(LEN)) chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
   .tck(tck), .tms(tms), .tdi(tdi), .chain_selected(chain_selected), .tdo_out(tdo_out),
   .tdo_oe(tdo_oe), .capture_bits(capture_bits), .analog_cmp_result(analog_cmp_result),
   .analog_above_level(analog_above_level), .update_cells(update_cells),
   .converter_ready(converter_ready), .conv_cmp_result(conv_cmp_result));

// ===== tb/abs_tester.sv
// Boundary-scan tester model driving the test pins and collecting serial output.
`timescale 1ns/10ps
`include "abs_consts.vh"
module abs_tester (
   // Clock
   input  wire sys_clk,
   // Test pins
   input  wire tdo_out,
   output reg  tck,
   output reg  tms,
   output reg  tdi
);
   reg obs;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      obs = 1'b0;
   end
   // One 180 ns test clock period; the clock stands still between calls.
   task tick(input m, input d);
      begin
         @(posedge sys_clk);
         tck <= 1'b0;
         tms <= m;
         tdi <= d;
         repeat (4) @(posedge sys_clk);
         tck <= 1'b1;
         repeat (2) @(posedge sys_clk);
         obs = tdo_out;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   // Idle to Update-DR and back; tdi toggles wherever it is not sampled.
   task scan(input [`ABS_CHAIN_LEN-1:0] din, output [`ABS_CHAIN_LEN-1:0] dout);
      integer i;
      begin
         tick(1'b1, ~tdi);
         tick(1'b0, ~tdi);
         tick(1'b0, ~tdi);
         for (i = 0; i < `ABS_CHAIN_LEN; i = i + 1) begin
            tick(i == `ABS_CHAIN_LEN - 1, din[i]);
            if (i > 0) dout[i-1] = obs;
         end
         tick(1'b1, ~tdi);
         dout[`ABS_CHAIN_LEN-1] = obs;
         tick(1'b0, ~tdi);
      end
   endtask
endmodule // abs_tester

// ===== tb/tb_adc_boundary_scan_chain.sv
// Self-checking bench for the boundary-scan chain with converter cells.
`timescale 1ns/10ps
`include "abs_consts.vh"
module tb_adc_boundary_scan_chain;
   localparam L = `ABS_CHAIN_LEN;
   localparam [L-1:0] ALL = {L{1'b1}};
   localparam [L-1:0] MSK = ~({{(L-1){1'b0}}, 1'b1} << `ABS_POS_CONV_RESULT);
   localparam [6:0] T_HOLD = 7'h1d, T_CMP_LATCH_PRECHARGE_N = 7'h77, T_ABOVE = 7'h03, T_EXP = 7'h2c;
   reg          sys_clk, arst_n, chain_selected, analog_cmp_result, analog_above_level;
   reg  [L-1:0] capture_bits, din, dout, exp_cap, prev;
   wire         tck, tms, tdi, tdo_out, tdo_oe, converter_ready, conv_cmp_result;
   wire [L-1:0] update_cells;
   integer      seed, n_errors, samples_checked, k, w;
   abs_chain #(.LEN(L)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .tck(tck), .tms(tms),
      .tdi(tdi), .chain_selected(chain_selected), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
      .capture_bits(capture_bits), .analog_cmp_result(analog_cmp_result),
      .analog_above_level(analog_above_level), .update_cells(update_cells),
      .converter_ready(converter_ready), .conv_cmp_result(conv_cmp_result));
   abs_tester tst_u (.sys_clk(sys_clk), .tdo_out(tdo_out), .tck(tck), .tms(tms), .tdi(tdi));
   always #10 sys_clk = ~sys_clk;
   task end_sim;
      begin
         $display("compared %0d mismatched %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task check_vec(input [L-1:0] got, input [L-1:0] exp, input [L-1:0] m);
      begin
         samples_checked = samples_checked + 1;
         if ((got & m) !== (exp & m)) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task check_bit(input got, input exp);
      check_vec({{(L-1){1'b0}}, got}, {{(L-1){1'b0}}, exp}, ALL);
   endtask
   task rnd(output [L-1:0] v);
      reg [159:0] t;
      begin
         t = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
         v = t[L-1:0];
      end
   endtask
   // Converter step with all other cells zero, so the channel pin is an input.
   function [L-1:0] step_vec(input [9:0] lvl, input hold, input cmp_latch_precharge_n);
      begin
         step_vec = {L{1'b0}};
         step_vec[`ABS_POS_CONV_EN] = 1'b1;
         step_vec[`ABS_POS_LEVEL_MSB:`ABS_POS_LEVEL_LSB] = lvl;
         step_vec[`ABS_POS_CHAN_MSB:`ABS_POS_CHAN_LSB] = 8'h08;
         step_vec[`ABS_POS_BYPASS] = 1'b1;
         step_vec[`ABS_POS_PASSGATE] = 1'b1;
         step_vec[`ABS_POS_HOLD] = hold;
         step_vec[`ABS_POS_CMP_LATCH_PRECHARGE_N_N] = cmp_latch_precharge_n;
      end
   endfunction
   initial begin
      sys_clk = 1'b0;
      arst_n = 1'b0;
      chain_selected = 1'b1;
      capture_bits = {L{1'b0}};
      analog_cmp_result = 1'b0;
      analog_above_level = 1'b0;
      seed = 32'h2a59_873e;
      n_errors = 0;
      samples_checked = 0;
      prev = {L{1'b0}};
      repeat (10) @(posedge sys_clk);
      check_vec(update_cells, {L{1'b0}}, ALL);
      check_bit(converter_ready, 1'b0);
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      tst_u.tick(1'b0, 1'b1);
      for (k = 0; k < 4; k = k + 1) begin
         rnd(din);
         din[`ABS_POS_RSV_A] = 1'b0;
         din[`ABS_POS_RSV_B] = 1'b0;
         rnd(exp_cap);
         @(posedge sys_clk);
         capture_bits <= exp_cap;
         analog_cmp_result <= din[0];
         chain_selected <= (k != 2);
         exp_cap[`ABS_POS_CMP_RESULT] = din[0];
         tst_u.scan(din, dout);
         if (k != 2) begin
            check_vec(dout, exp_cap, MSK);
            check_vec(update_cells, din, ALL);
            prev = din;
         end
         else check_vec(update_cells, prev, ALL);
      end
      chain_selected <= 1'b1;
      repeat (5) tst_u.tick(1'b1, 1'b0);
      check_vec(update_cells, {L{1'b0}}, ALL);
      tst_u.tick(1'b0, 1'b0);
      for (k = 0; k < 7; k = k + 1) begin
         tst_u.scan(step_vec((k == 3) ? 10'h123 : `ABS_LEVEL_MID, T_HOLD[k], T_CMP_LATCH_PRECHARGE_N[k]),
            dout);
         if (k > 1) check_bit(dout[`ABS_POS_CONV_RESULT], T_EXP[k]);
         @(posedge sys_clk);
         analog_above_level <= T_ABOVE[k];
         for (w = 0; k == 0 && w < 100 && converter_ready !== 1'b1; w = w + 1)
            @(posedge sys_clk);
         if (k == 0) check_bit(converter_ready, 1'b1);
         if (k == 0 && w == 100) end_sim;
      end
      end_sim;
   end
endmodule // tb_adc_boundary_scan_chain
